// file: dv/dsxmb_bus_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dsxmb_bus_tb import dsxmb_pkg::*;;
   logic clock = 1'b0, rst = 1'b1, req = 1'b0, req_write = 1'b0, sleep_cmd = 1'b0;
   logic fetch = 1'b0, fetch_low;
   logic [1:0] req_space = 2'h0;
   logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, ram_rdata = 16'h0000;
   logic [3:0] wait_cfg = 4'h0, ext_n = 4'hF, stall = 4'h0;
   logic off_n = 1'b1, hold_n = 1'b1, br_n = 1'b1, dma_rw = 1'b1, stb_n = 1'b1, drv = 1'b0;
   logic [15:0] dma_a = 16'h0000, dma_d = 16'h0000, last_d = 16'h0000, sa, sd;
   logic done, asleep, ram_en, ram_we, a_oe_n, d_oe_n, ps_n, ds_n, is_n, ctl_oe_n;
   logic rw_out, stb_out, rd_n, br_out, br_oe_n, grant_n, fetch_n, ready, q_en, br_low;
   logic [15:0] rdata, ram_addr, ram_wdata, a_out, d_out, q;
   logic [5:0] snap;
   int num_errors = 0, total_checks = 0, n;
   wire logic [15:0] a_in = a_oe_n ? dma_a : a_out;
   wire logic [15:0] d_in = !d_oe_n ? d_out : drv ? dma_d : (q_en && !ctl_oe_n) ? q : ~last_d;
   wire logic rw_in = ctl_oe_n ? dma_rw : rw_out;
   wire logic stb_in = ctl_oe_n ? stb_n : stb_out;
   wire logic br_in = br_oe_n ? br_n : br_out;
   always #10 clock = ~clock;
   always @(posedge clock) last_d <= d_in;

   dsxmb_bus i_dsxmb_bus (.clock(clock), .rst(rst), .req(req), .req_write(req_write),
      .req_space(req_space), .req_fetch(fetch), .req_addr(req_addr), .req_wdata(req_wdata),
      .wait_cfg(wait_cfg), .global_base(16'h8000), .sleep_cmd(sleep_cmd), .done(done),
      .rdata(rdata), .asleep(asleep), .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .output_float_n(off_n),
      .hold_req_n(hold_n), .ready(ready), .external_interrupts_n(ext_n),
      .address_lines_in(a_in), .address_lines_out(a_out), .address_lines_oe_n(a_oe_n),
      .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe_n(d_oe_n),
      .program_space_select_n(ps_n), .data_space_select_n(ds_n), .io_space_select_n(is_n),
      .ctl_oe_n(ctl_oe_n), .rw_in(rw_in), .rw_out(rw_out), .bus_cycle_strobe_in(stb_in),
      .bus_cycle_strobe_out(stb_out), .read_select_n(rd_n), .bus_request_line_in(br_in),
      .bus_request_line_out(br_out), .bus_request_line_oe_n(br_oe_n),
      .takeover_grant_n(grant_n), .fetch_indicator_n(fetch_n));
   dsxmb_mem_model i_dsxmb_mem_model (.clock(clock), .addr(a_out), .wdata(d_out),
      .strobe_n(stb_out), .rw(rw_out), .rd_n(rd_n), .br_n(br_out), .stall(stall),
      .ready(ready), .q(q), .q_en(q_en));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   // one core access; snapshot of the pins taken while strobe is low
   task automatic access(input logic wr, input logic [1:0] sp, input logic [15:0] a,
         input logic [15:0] wd);
      req_write = wr;
      req_space = sp;
      req_addr = a;
      req_wdata = wd;
      req = 1'b1;
      n = 0;
      br_low = 1'b0;
      fetch_low = 1'b0;
      while (done !== 1'b1) begin
         tick(1);
         n++;
         if (br_out === 1'b0) br_low = 1'b1;
         if (fetch_n === 1'b0) fetch_low = 1'b1;
         if (stb_out === 1'b0) begin
            snap = {ps_n, ds_n, is_n, rw_out, rd_n, d_oe_n};
            sa = a_out;
            sd = d_out;
         end
         if (n > 60) begin
            num_errors++;
            end_sim();
         end
      end
      req = 1'b0;
      tick(1);
   endtask
   task automatic t_reset;
      check({ps_n, ds_n, is_n, stb_out, rw_out, rd_n, grant_n, fetch_n, d_oe_n}, 9'h1FF);
      check(a_oe_n, 1'b0);
      $display("reset test done");
   endtask
   task automatic t_spaces;
      for (int s = 0; s < 3; s++) begin
         access(1'b1, 2'(s), 16'h0010 + 16'(s), 16'hA5C0 + 16'(s));
         check(snap, {~(3'h4 >> s), 3'h2});
         check(sd, 16'hA5C0 + 16'(s));
         check(n, 2);
         fetch = 1'(s == 0);
         access(1'b0, 2'(s), 16'h0010 + 16'(s), 16'h0000);
         fetch = 1'b0;
         check(fetch_low, 1'(s == 0));
         check(snap, {~(3'h4 >> s), 3'h5});
         check(sa, 16'h0010 + 16'(s));
         check(rdata, 16'hA5C0 + 16'(s));
         check(br_low, 1'b0);
      end
      $display("space test done");
   endtask
   task automatic t_waits;
      for (int i = 0; i < 2; i++) begin
         wait_cfg = i ? 4'hF : 4'h1;
         access(1'b0, 2'h1, 16'h0011, 16'h0000);
         check(n, 2 + int'(wait_cfg));
      end
      wait_cfg = 4'h0;
      stall = 4'h3;
      access(1'b0, 2'h2, 16'h0012, 16'h0000);
      check(n, 5);
      check(rdata, 16'hA5C2);
      stall = 4'h2;
      access(1'b1, 2'h1, 16'h8004, 16'h3C96);
      check({br_low, 1'(n == 5)}, 2'h3);
      access(1'b0, 2'h1, 16'h8004, 16'h0000);
      check({br_low, rdata}, {1'b1, 16'h3C96});
      stall = 4'h0;
      $display("wait test done");
   endtask
   task automatic t_float;
      off_n = 1'b0;
      tick(2);
      check({a_oe_n, ctl_oe_n, d_oe_n, br_oe_n}, 4'hF);
      off_n = 1'b1;
      tick(2);
      check({a_oe_n, ctl_oe_n}, 2'h0);
      $display("float test done");
   endtask
   task automatic t_hold;
      hold_n = 1'b0;
      tick(2);
      check({grant_n, a_oe_n, d_oe_n}, 3'h3);
      br_n = 1'b0;
      dma_a = 16'h0123;
      dma_rw = 1'b0;
      dma_d = 16'hBEEF;
      drv = 1'b1;
      tick(2);
      check(fetch_n, 1'b0);
      stb_n = 1'b0;
      n = 0;
      repeat (4) begin
         tick(1);
         if (ram_en === 1'b1) begin
            n++;
            check({ram_we, ram_addr, ram_wdata}, {1'b1, 16'h0123, 16'hBEEF});
         end
      end
      check(n, 1);
      stb_n = 1'b1;
      drv = 1'b0;
      dma_rw = 1'b1;
      dma_a = 16'h0456;
      ram_rdata = 16'h5A3C;
      tick(1);
      stb_n = 1'b0;
      tick(3);
      check({d_oe_n, d_out}, {1'b0, 16'h5A3C});
      stb_n = 1'b1;
      br_n = 1'b1;
      tick(1);
      hold_n = 1'b1;
      tick(2);
      check(grant_n, 1'b1);
      $display("hold test done");
   endtask
   task automatic t_sleep;
      sleep_cmd = 1'b1;
      tick(2);
      sleep_cmd = 1'b0;
      check(asleep, 1'b1);
      ext_n = 4'hE;
      tick(WAKE_LOW_CYCLES - 1);
      ext_n = 4'hF;
      tick(2);
      check(asleep, 1'b1);
      ext_n = 4'h7;
      tick(WAKE_LOW_CYCLES + 2);
      ext_n = 4'hF;
      check(asleep, 1'b0);
      $display("sleep test done");
   endtask
   initial begin
      tick(4);
      rst = 1'b0;
      tick(1);
      t_reset();
      t_spaces();
      t_waits();
      t_float();
      t_hold();
      t_sleep();
      end_sim();
   end
endmodule
`default_nettype wire

// file: dv/dsxmb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsxmb_mem_model (
   // clock
   input wire logic clock,
   // bus from the device, and the stall count from the test
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic strobe_n,
   input wire logic rw,
   input wire logic rd_n,
   input wire logic br_n,
   input wire logic [3:0] stall,
   // answer
   output logic ready,
   output logic [15:0] q,
   output logic q_en
);
   logic [15:0] mem [16];
   logic [3:0] cnt = 4'h0;
   // ready stays low until the stall count has run, also as grant
   assign ready = (cnt >= stall);
   assign q_en = !rd_n;
   assign q = mem[addr[3:0]];
   always @(posedge clock) begin
      cnt <= (!strobe_n || !br_n) ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
      // keep last word seen while strobe low, so the rise latches it
      if (!strobe_n && !rw) begin
         mem[addr[3:0]] <= wdata;
      end
   end
endmodule
`default_nettype wire

// file: pkg/dsxmb_pkg.sv
package dsxmb_pkg;
   // ****************************************
   // widths and spaces
   // ****************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [16:0] PROG_SPACE_WORDS = 17'h10000;
   localparam logic [16:0] DATA_SPACE_WORDS = 17'h10000;
   localparam logic [16:0] IO_SPACE_WORDS = 17'h10000;
   localparam logic [16:0] GLOBAL_SPACE_WORDS = 17'h08000;
   localparam logic [15:0] GLOBAL_BASE_RESET = 16'h8000;
   localparam logic [3:0] WAIT_RESET = 4'hF;
   localparam int WAKE_LOW_CYCLES = 5;
   localparam logic [2:0] WAKE_CNT_TOP = 3'(WAKE_LOW_CYCLES);

   typedef enum logic [1:0] {
      DSXMB_SP_PROG = 2'h0,
      DSXMB_SP_DATA = 2'h1,
      DSXMB_SP_IO = 2'h2
   } dsxmb_space_t;

   typedef enum logic [5:0] {
      DSXMB_IDLE = 6'h01,
      DSXMB_GRANT = 6'h02,
      DSXMB_WAIT = 6'h04,
      DSXMB_READY = 6'h08,
      DSXMB_HOLD = 6'h10,
      DSXMB_SLEEP = 6'h20
   } dsxmb_state_t;
endpackage

// file: rtl/dsxmb_bus.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - program, data, io spaces of 64K words each; up to 32K global data words sit at the top of data space
// - one shared 16-bit address bus, space selects tell the spaces apart
// - address lines float in hold and while output float is low
// - in hold with bus request driven low outside, address lines are inputs
// - data bus floats unless writing or driving an outside DMA read; floats in reset and output float
// - during outside DMA, data lines carry words to and from on-chip RAM
// - space selects idle high; only the accessed space goes low
// - selects, direction, strobe, read select float in hold or output float
// - low ready stretches the cycle; ready is sampled again each cycle
// - after bus request, ready acts as grant; cycle waits for it
// - direction line high for read, low only during a write
// - strobe high, low only during an external bus cycle
// - read select low on every external read
// - sixteen programmable wait-state settings lengthen accesses
// - deep sleep stops core; five low cycles on an interrupt wake it
// - hold request answered, outside deep sleep, by floating lines and grant going low
// - bus request asserted during global data accesses
// - in hold, fetch indicator acknowledges outside RAM requests
// - write data driven from strobe fall, latched by memory at its rise
module dsxmb_bus
   import dsxmb_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // core request side
   input wire logic req,
   input wire logic req_write,
   input wire logic [1:0] req_space,
   input wire logic req_fetch,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic [3:0] wait_cfg,
   input wire logic [15:0] global_base,
   input wire logic sleep_cmd,
   output logic done,
   output logic [15:0] rdata,
   output logic asleep,
   // on-chip RAM port for outside DMA
   output logic ram_en,
   output logic ram_we,
   output logic [15:0] ram_addr,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata,
   // pins
   input wire logic output_float_n,
   input wire logic hold_req_n,
   input wire logic ready,
   input wire logic [3:0] external_interrupts_n,
   input wire logic [15:0] address_lines_in,
   output logic [15:0] address_lines_out,
   output logic address_lines_oe_n,
   input wire logic [15:0] data_lines_in,
   output logic [15:0] data_lines_out,
   output logic data_lines_oe_n,
   output logic program_space_select_n,
   output logic data_space_select_n,
   output logic io_space_select_n,
   output logic ctl_oe_n,
   input wire logic rw_in,
   output logic rw_out,
   input wire logic bus_cycle_strobe_in,
   output logic bus_cycle_strobe_out,
   output logic read_select_n,
   input wire logic bus_request_line_in,
   output logic bus_request_line_out,
   output logic bus_request_line_oe_n,
   output logic takeover_grant_n,
   output logic fetch_indicator_n
);
   typedef struct packed {
      dsxmb_state_t st;
      logic [3:0] wcnt;
      logic [2:0] wake;
      logic write;
      logic glob;
      logic done;
      logic [15:0] rdata;
      logic asleep;
      logic ram_en;
      logic ram_we;
      logic [15:0] ram_addr;
      logic [15:0] ram_wdata;
      logic [15:0] a_out;
      logic a_oe_n;
      logic [15:0] d_out;
      logic d_oe_n;
      logic ps_n;
      logic ds_n;
      logic is_n;
      logic ctl_oe_n;
      logic rw;
      logic bus_cycle_strobe;
      logic rd_n;
      logic br;
      logic br_oe_n;
      logic hlda_n;
      logic iaq_n;
      logic bus_cycle_strobe_q;
   } dsxmb_regs_t;

   dsxmb_regs_t r;
   dsxmb_regs_t next_r;
   logic any_int_low;
   logic dma_on;

   assign any_int_low = ~&external_interrupts_n;
   assign dma_on = (r.st == DSXMB_HOLD) && !bus_request_line_in;

   // ****************************************
   // bus sequencer
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.ram_en = 1'b0;
      // float follows the pin at the next clock edge, in every state
      next_r.ctl_oe_n = !output_float_n || (r.st == DSXMB_HOLD) || (r.st == DSXMB_SLEEP);
      next_r.a_oe_n = next_r.ctl_oe_n;
      next_r.br_oe_n = !output_float_n || !r.glob;
      next_r.iaq_n = 1'b1;
      // write data drops off the pins at the next clock edge if output float goes low mid-cycle
      next_r.d_oe_n = r.bus_cycle_strobe || !r.write || !output_float_n;
      case (r.st)
         DSXMB_IDLE: begin
            next_r.d_oe_n = 1'b1;
            if (!hold_req_n) begin
               next_r.st = DSXMB_HOLD;
               next_r.hlda_n = 1'b0;
               next_r.ctl_oe_n = 1'b1;
               next_r.a_oe_n = 1'b1;
            end else if (sleep_cmd) begin
               next_r.st = DSXMB_SLEEP;
               next_r.asleep = 1'b1;
               next_r.wake = 3'h0;
            end else if (req) begin
               next_r.a_out = req_addr;
               next_r.write = req_write;
               next_r.ps_n = req_space != DSXMB_SP_PROG;
               next_r.ds_n = req_space != DSXMB_SP_DATA;
               next_r.is_n = req_space != DSXMB_SP_IO;
               next_r.iaq_n = !req_fetch;
               // global window sits at the top of data space
               next_r.glob = (req_space == DSXMB_SP_DATA) && (req_addr >= global_base)
                  && (17'(req_addr) >= DATA_SPACE_WORDS - GLOBAL_SPACE_WORDS);
               next_r.br = !next_r.glob;
               next_r.bus_cycle_strobe = 1'b0;
               next_r.rw = !req_write;
               next_r.rd_n = req_write;
               next_r.d_out = req_wdata;
               next_r.d_oe_n = !req_write || !output_float_n;
               next_r.wcnt = wait_cfg;
               next_r.st = next_r.glob ? DSXMB_GRANT : (wait_cfg != 4'h0) ? DSXMB_WAIT : DSXMB_READY;
            end
         end
         DSXMB_GRANT: begin
            if (ready) begin
               next_r.st = (r.wcnt != 4'h0) ? DSXMB_WAIT : DSXMB_READY;
            end
         end
         DSXMB_WAIT: begin
            next_r.wcnt = r.wcnt - 4'h1;
            if (r.wcnt == 4'h1) begin
               next_r.st = DSXMB_READY;
            end
         end
         DSXMB_READY: begin
            if (ready) begin
               next_r.done = 1'b1;
               if (!r.write) begin
                  next_r.rdata = data_lines_in;
               end
               next_r.st = DSXMB_IDLE;
               next_r.ps_n = 1'b1;
               next_r.ds_n = 1'b1;
               next_r.is_n = 1'b1;
               next_r.bus_cycle_strobe = 1'b1;
               next_r.rw = 1'b1;
               next_r.rd_n = 1'b1;
               next_r.br = 1'b1;
               next_r.glob = 1'b0;
               next_r.br_oe_n = !output_float_n;
               next_r.d_oe_n = 1'b1;
            end
         end
         DSXMB_HOLD: begin
            next_r.d_oe_n = 1'b1;
            // outside master owns the pins; on-chip RAM follows them
            if (dma_on) begin
               next_r.iaq_n = 1'b0;
               next_r.ram_addr = address_lines_in;
               next_r.ram_we = !rw_in;
               next_r.ram_wdata = data_lines_in;
               next_r.ram_en = r.bus_cycle_strobe_q && !bus_cycle_strobe_in;
               // read data out while the master reads with strobe low
               next_r.d_out = ram_rdata;
               next_r.d_oe_n = !output_float_n || !rw_in || bus_cycle_strobe_in;
            end
            if (hold_req_n) begin
               next_r.st = DSXMB_IDLE;
               next_r.hlda_n = 1'b1;
            end
         end
         DSXMB_SLEEP: begin
            next_r.d_oe_n = 1'b1;
            next_r.wake = any_int_low ? ((r.wake == WAKE_CNT_TOP) ? r.wake : r.wake + 3'h1)
                                      : 3'h0;
            if (any_int_low && r.wake == WAKE_CNT_TOP - 3'h1) begin
               next_r.st = DSXMB_IDLE;
               next_r.asleep = 1'b0;
            end
         end
         default: begin
            next_r.st = DSXMB_IDLE;
         end
      endcase
      next_r.bus_cycle_strobe_q = bus_cycle_strobe_in;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         r <= '{st: DSXMB_IDLE, wcnt: 4'h0, wake: 3'h0, write: 1'b0, glob: 1'b0,
                done: 1'b0, rdata: 16'h0000, asleep: 1'b0, ram_en: 1'b0,
                ram_we: 1'b0, ram_addr: 16'h0000, ram_wdata: 16'h0000,
                a_out: 16'h0000, a_oe_n: 1'b0, d_out: 16'h0000, d_oe_n: 1'b1,
                ps_n: 1'b1, ds_n: 1'b1, is_n: 1'b1, ctl_oe_n: 1'b0, rw: 1'b1,
                bus_cycle_strobe: 1'b1, rd_n: 1'b1, br: 1'b1, br_oe_n: 1'b1, hlda_n: 1'b1,
                iaq_n: 1'b1, bus_cycle_strobe_q: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign done = r.done;
   assign rdata = r.rdata;
   assign asleep = r.asleep;
   assign ram_en = r.ram_en;
   assign ram_we = r.ram_we;
   assign ram_addr = r.ram_addr;
   assign ram_wdata = r.ram_wdata;
   assign address_lines_out = r.a_out;
   assign address_lines_oe_n = r.a_oe_n;
   assign data_lines_out = r.d_out;
   assign data_lines_oe_n = r.d_oe_n;
   assign program_space_select_n = r.ps_n;
   assign data_space_select_n = r.ds_n;
   assign io_space_select_n = r.is_n;
   assign ctl_oe_n = r.ctl_oe_n;
   assign rw_out = r.rw;
   assign bus_cycle_strobe_out = r.bus_cycle_strobe;
   assign read_select_n = r.rd_n;
   assign bus_request_line_out = r.br;
   assign bus_request_line_oe_n = r.br_oe_n;
   assign takeover_grant_n = r.hlda_n;
   assign fetch_indicator_n = r.iaq_n;

   // ****************************************
   // checks
   // ****************************************
   property p_one_select;
      @(posedge clock) disable iff (rst)
      $countones({r.ps_n, r.ds_n, r.is_n}) >= 2;
   endproperty
   a_one_select: assert property (p_one_select) else $error("two space selects low");

   property p_float_in_hold;
      @(posedge clock) disable iff (rst)
      (!takeover_grant_n) |-> (address_lines_oe_n && ctl_oe_n);
   endproperty
   a_float_in_hold: assert property (p_float_in_hold) else $error("pins driven in hold");

   property p_float_pin;
      @(posedge clock) disable iff (rst)
      !output_float_n |=> (ctl_oe_n && address_lines_oe_n && data_lines_oe_n);
   endproperty
   a_float_pin: assert property (p_float_pin) else $error("pins driven with float low");

   property p_rw_write_only;
      @(posedge clock) disable iff (rst)
      !rw_out |-> !bus_cycle_strobe_out && read_select_n;
   endproperty
   a_rw_write_only: assert property (p_rw_write_only) else $error("write outside cycle");

   property p_rd_on_read;
      @(posedge clock) disable iff (rst)
      (!bus_cycle_strobe_out && rw_out) |-> !read_select_n;
   endproperty
   a_rd_on_read: assert property (p_rd_on_read) else $error("read select missing");

   property p_ready_stretch;
      @(posedge clock) disable iff (rst)
      (r.st == DSXMB_READY && !ready) |=> !done && !bus_cycle_strobe_out;
   endproperty
   a_ready_stretch: assert property (p_ready_stretch) else $error("ended without ready");

   property p_grant_wait;
      @(posedge clock) disable iff (rst)
      (r.st == DSXMB_GRANT && !ready) |=> (r.st == DSXMB_GRANT);
   endproperty
   a_grant_wait: assert property (p_grant_wait) else $error("left grant early");

   sequence s_low_run;
      any_int_low [*5];
   endsequence
   property p_wake;
      @(posedge clock) disable iff (rst)
      (r.st == DSXMB_SLEEP && !any_int_low) ##1 s_low_run |=> !asleep;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake after five low");

   property p_write_data;
      @(posedge clock) disable iff (rst)
      (!bus_cycle_strobe_out && !rw_out && output_float_n && $past(output_float_n))
         |-> !data_lines_oe_n;
   endproperty
   a_write_data: assert property (p_write_data) else $error("write data not driven");
endmodule
`default_nettype wire
